//--- src/flash_command_interface.sv
// Host controller that drives a parallel flash through its pins from APB orders.
//
// Decided for this implementation: the APB register port and the register offsets.
`default_nettype none
module flash_command_interface (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic      [18:0] flash_addr,
   output logic      [7:0]  flash_dq_out,
   output logic             flash_dq_oe,
   input  wire logic [7:0]  flash_dq_in,
   output logic             flash_ce_n,
   output logic             flash_oe_n,
   output logic             flash_we_n
);
   typedef enum {IDLE, SEQ_SETUP, WE_LOW, WE_HIGH, RD_LOW, RD_SAMPLE, RD_GAP, WAIT_RST}
      phase_e;

   typedef struct packed {
      phase_e      phase;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic [18:0] flash_addr;
      logic [7:0]  flash_dq_out;
      logic        flash_dq_oe;
      logic        flash_ce_n;
      logic        flash_oe_n;
      logic        flash_we_n;
      logic [2:0]  op;
      logic [2:0]  step;
      logic [18:0] user_addr;
      logic [7:0]  user_data;
      logic [7:0]  rd_data;
      logic [7:0]  prev_rd;
      logic        busy;
      logic        erase_active;
      logic        erase_done;
      logic        erase_failed;
      logic        rd_count;
      logic [3:0]  tcnt;
      logic [8:0]  wcnt;
   } state_s;

   state_s st_reg, st_next;
   logic [7:0] dq_meta_reg, dq_sync_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dq_meta_reg <= 8'h00;
         dq_sync_reg <= 8'h00;
      end else begin
         dq_meta_reg <= flash_dq_in;
         dq_sync_reg <= dq_meta_reg;
      end
   end

   // Returns address and data of write cycle n of the current sequence.
   function automatic logic [26:0] seq_word(input logic [2:0] op, input logic [2:0] n,
                                            input logic [18:0] a, input logic [7:0] d);
      logic [26:0] r;
      r = {flash_host_pkg::UNLOCK_ADDR1, flash_host_pkg::CMD_RESET};
      unique case (n)
         3'h0, 3'h3: r = {flash_host_pkg::UNLOCK_ADDR1, flash_host_pkg::UNLOCK_DATA1};
         3'h1, 3'h4: r = {flash_host_pkg::UNLOCK_ADDR2, flash_host_pkg::UNLOCK_DATA2};
         3'h2: r = {flash_host_pkg::UNLOCK_ADDR1, (op == flash_host_pkg::OP_SIGNATURE) ?
                    flash_host_pkg::CMD_SIG : flash_host_pkg::CMD_SETUP};
         3'h5: r = {flash_host_pkg::UNLOCK_ADDR1, flash_host_pkg::CMD_CHIP};
         default: r = {a, d};
      endcase
      // A raw write sends the user's own address and byte, with no unlock pair in front.
      if (op == flash_host_pkg::OP_WRITE) begin
         r = {a, d};
      end
      return r;
   endfunction : seq_word

   function automatic logic [2:0] seq_len(input logic [2:0] op);
      logic [2:0] r;
      r = 3'h1;
      if (op == flash_host_pkg::OP_SIGNATURE) begin
         r = 3'h3;
      end else if (op == flash_host_pkg::OP_CHIP_ERASE) begin
         r = 3'h6;
      end
      return r;
   endfunction : seq_len

   always_comb begin
      logic        wr_acc;
      logic        rd_acc;
      logic [26:0] w;
      logic [2:0]  op_in;
      wr_acc = 1'b0;
      rd_acc = 1'b0;
      w = 27'h0;
      op_in = 3'h0;
      st_next = st_reg;
      st_next.pready = 1'b0;
      st_next.pslverr = 1'b0;
      if (psel && !penable && !st_reg.pready) begin
         st_next.pready = 1'b1;
         wr_acc = pwrite;
         rd_acc = !pwrite;
      end
      if (rd_acc) begin
         unique case (paddr)
            flash_host_pkg::CTRL_OFFSET:   st_next.prdata = {29'h0, st_reg.op};
            flash_host_pkg::ADDR_OFFSET:   st_next.prdata = {13'h0, st_reg.user_addr};
            flash_host_pkg::WDATA_OFFSET:  st_next.prdata = {24'h0, st_reg.user_data};
            flash_host_pkg::STATUS_OFFSET:
               st_next.prdata = {28'h0, st_reg.erase_failed, st_reg.erase_done,
                                 st_reg.erase_active, st_reg.busy};
            flash_host_pkg::RDATA_OFFSET:  st_next.prdata = {24'h0, st_reg.rd_data};
            default: begin
               st_next.prdata = 32'h0;
               st_next.pslverr = 1'b1;
            end
         endcase
      end
      if (wr_acc) begin
         unique case (paddr)
            flash_host_pkg::CTRL_OFFSET: begin
               op_in = pwdata[2:0];
               // while an erase runs only reset, status poll and read are sent.
               if (st_reg.busy || (st_reg.erase_active && op_in != flash_host_pkg::OP_RESET
                   && op_in != flash_host_pkg::OP_POLL && op_in != flash_host_pkg::OP_READ))
                  begin
                  st_next.pslverr = 1'b1;
               end else begin
                  st_next.op = op_in;
                  st_next.busy = 1'b1;
                  st_next.step = 3'h0;
                  st_next.phase = SEQ_SETUP;
               end
            end
            flash_host_pkg::ADDR_OFFSET:  st_next.user_addr = pwdata[18:0];
            flash_host_pkg::WDATA_OFFSET: st_next.user_data = pwdata[7:0];
            default: st_next.pslverr = 1'b1;
         endcase
      end
      st_next.tcnt = (st_reg.tcnt == 4'h0) ? 4'h0 : 4'(st_reg.tcnt - 4'h1);
      unique case (st_reg.phase)
         IDLE: begin
            st_next.flash_ce_n = 1'b1;
            st_next.flash_oe_n = 1'b1;
            st_next.flash_we_n = 1'b1;
            st_next.flash_dq_oe = 1'b0;
         end
         SEQ_SETUP: begin
            if (st_reg.op == flash_host_pkg::OP_READ || st_reg.op == flash_host_pkg::OP_POLL)
               begin
               st_next.flash_addr = st_reg.user_addr;
               st_next.flash_ce_n = 1'b0;
               st_next.flash_oe_n = 1'b0;
               st_next.tcnt = 4'(flash_host_pkg::STROBE_CYCLES);
               st_next.phase = RD_LOW;
            end else begin
               w = seq_word(st_reg.op, st_reg.step, st_reg.user_addr, st_reg.user_data);
               if (st_reg.op == flash_host_pkg::OP_RESET) begin
                  w = {st_reg.user_addr, flash_host_pkg::CMD_RESET};
               end
               st_next.flash_addr = w[26:8];
               st_next.flash_dq_out = w[7:0];
               st_next.flash_dq_oe = 1'b1;
               st_next.flash_ce_n = 1'b0;
               st_next.flash_we_n = 1'b0;
               st_next.tcnt = 4'(flash_host_pkg::STROBE_CYCLES);
               st_next.phase = WE_LOW;
            end
         end
         WE_LOW: begin
            if (st_reg.tcnt == 4'h0) begin
               st_next.flash_we_n = 1'b1;
               st_next.flash_ce_n = 1'b1;
               st_next.tcnt = 4'(flash_host_pkg::STROBE_CYCLES);
               st_next.phase = WE_HIGH;
            end
         end
         WE_HIGH: begin
            if (st_reg.tcnt == 4'h0) begin
               st_next.flash_dq_oe = 1'b0;
               if (3'(st_reg.step + 3'h1) < seq_len(st_reg.op)) begin
                  st_next.step = 3'(st_reg.step + 3'h1);
                  st_next.phase = SEQ_SETUP;
               end else if (st_reg.op == flash_host_pkg::OP_RESET) begin
                  st_next.erase_failed = 1'b0;
                  st_next.erase_active = 1'b0;
                  st_next.wcnt = 9'(flash_host_pkg::RESET_WAIT_CYC);
                  st_next.phase = WAIT_RST;
               end else begin
                  if (st_reg.op == flash_host_pkg::OP_CHIP_ERASE) begin
                     st_next.erase_active = 1'b1;
                     st_next.erase_done = 1'b0;
                     st_next.erase_failed = 1'b0;
                     st_next.rd_count = 1'b0;
                  end
                  st_next.busy = 1'b0;
                  st_next.phase = IDLE;
               end
            end
         end
         RD_LOW: begin
            if (st_reg.tcnt == 4'h0) begin
               st_next.tcnt = 4'h3;
               st_next.phase = RD_SAMPLE;
            end
         end
         RD_SAMPLE: begin
            // Three cycles let the pin value pass the synchroniser.
            if (st_reg.tcnt == 4'h0) begin
               st_next.rd_data = dq_sync_reg;
               st_next.flash_ce_n = 1'b1;
               st_next.flash_oe_n = 1'b1;
               st_next.tcnt = 4'(flash_host_pkg::STROBE_CYCLES);
               st_next.phase = RD_GAP;
               if (st_reg.op == flash_host_pkg::OP_POLL && st_reg.erase_active) begin
                  // only bits 5, 6 and 7 are looked at.
                  st_next.rd_count = 1'b1;
                  if (st_reg.rd_count && dq_sync_reg[flash_host_pkg::POLLING_BIT] &&
                      dq_sync_reg[flash_host_pkg::TOGGLE_BIT] ==
                      st_reg.prev_rd[flash_host_pkg::TOGGLE_BIT]) begin
                     st_next.erase_active = 1'b0;
                     st_next.erase_done = 1'b1;
                  end
                  // Erased array data reads with bit 5 set too, so only a status read counts.
                  if (dq_sync_reg[flash_host_pkg::FAILURE_BIT] &&
                      !dq_sync_reg[flash_host_pkg::POLLING_BIT]) begin
                     st_next.erase_failed = 1'b1;
                  end
                  st_next.prev_rd = dq_sync_reg;
               end
            end
         end
         RD_GAP: begin
            if (st_reg.tcnt == 4'h0) begin
               st_next.busy = 1'b0;
               st_next.phase = IDLE;
            end
         end
         WAIT_RST: begin
            st_next.wcnt = 9'(st_reg.wcnt - 9'h1);
            if (st_reg.wcnt == 9'h0) begin
               st_next.busy = 1'b0;
               st_next.phase = IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
         st_reg.phase <= IDLE;
         st_reg.flash_ce_n <= 1'b1;
         st_reg.flash_oe_n <= 1'b1;
         st_reg.flash_we_n <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata       = st_reg.prdata;
   assign pready       = st_reg.pready;
   assign pslverr      = st_reg.pslverr;
   assign flash_addr   = st_reg.flash_addr;
   assign flash_dq_out = st_reg.flash_dq_out;
   assign flash_dq_oe  = st_reg.flash_dq_oe;
   assign flash_ce_n   = st_reg.flash_ce_n;
   assign flash_oe_n   = st_reg.flash_oe_n;
   assign flash_we_n   = st_reg.flash_we_n;
endmodule : flash_command_interface
`default_nettype wire

//--- src/flash_host_pkg.sv
// Package of constants for the parallel flash command controller.
`default_nettype none
package flash_host_pkg;
   // Register map of the controller (byte addresses on APB).
   localparam logic [11:0] CTRL_OFFSET   = 12'h000;
   localparam logic [11:0] ADDR_OFFSET   = 12'h004;
   localparam logic [11:0] WDATA_OFFSET  = 12'h008;
   localparam logic [11:0] STATUS_OFFSET = 12'h00c;
   localparam logic [11:0] RDATA_OFFSET  = 12'h010;
   // Command codes written to CTRL bits 2:0; writing CTRL starts an operation.
   localparam logic [2:0] OP_READ       = 3'h0;
   localparam logic [2:0] OP_WRITE      = 3'h1;
   localparam logic [2:0] OP_RESET      = 3'h2;
   localparam logic [2:0] OP_SIGNATURE  = 3'h3;
   localparam logic [2:0] OP_CHIP_ERASE = 3'h4;
   localparam logic [2:0] OP_POLL       = 3'h5;
   // Device addresses and data codes.
   localparam logic [18:0] UNLOCK_ADDR1 = 19'h05555;
   localparam logic [18:0] UNLOCK_ADDR2 = 19'h02aaa;
   localparam logic [7:0]  UNLOCK_DATA1 = 8'haa;
   localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
   localparam logic [7:0]  CMD_RESET    = 8'hf0;
   localparam logic [7:0]  CMD_SIG      = 8'h90;
   localparam logic [7:0]  CMD_SETUP    = 8'h80;
   localparam logic [7:0]  CMD_CHIP     = 8'h10;
   // Status bit positions on the data bus.
   localparam int TIMER_BIT   = 3;
   localparam int FAILURE_BIT = 5;
   localparam int TOGGLE_BIT  = 6;
   localparam int POLLING_BIT = 7;
   // Timing.
   localparam int CLK_MHZ         = 50;
   localparam int STROBE_CYCLES   = 4;
   localparam int RESET_WAIT_US   = 5;
   localparam int RESET_WAIT_CYC  = RESET_WAIT_US * CLK_MHZ;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
endpackage : flash_host_pkg
`default_nettype wire

//--- verification/flash_command_interface_monitor.sv
// Checker of the controller's flash pin and APB behaviour.
`default_nettype none
module flash_command_interface_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [18:0] flash_addr,
   input wire logic [7:0]  flash_dq_out,
   input wire logic        flash_dq_oe,
   input wire logic        flash_ce_n,
   input wire logic        flash_oe_n,
   input wire logic        flash_we_n
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [18:0] prev_a;
   logic [7:0]  prev_d;
   logic        in_erase;
   logic [8:0]  quiet;
   // Remembers the last completed write and counts cycles since a reset during erase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_a <= '0;
         prev_d <= '0;
         in_erase <= 1'b0;
         quiet <= 9'h1ff;
      end else if ($rose(flash_we_n)) begin
         prev_a <= flash_addr;
         prev_d <= flash_dq_out;
         if (flash_dq_out == 8'h10 && flash_addr == 19'h05555) in_erase <= 1'b1;
         if (flash_dq_out == 8'hf0) in_erase <= 1'b0;
         if (flash_dq_out == 8'hf0 && in_erase) quiet <= 9'h000;
      end else if (quiet != 9'h1ff) begin
         quiet <= quiet + 9'h001;
      end
   end
   sequence s_setup;
      psel && !penable && !pready;
   endsequence
   sequence s_we_pulse;
      (!flash_we_n)[*5] ##1 flash_we_n;
   endsequence
   sequence s_unlocked;
      prev_a == 19'h02aaa && prev_d == 8'h55;
   endsequence
   a_we_low_span: assert property ($fell(flash_we_n) |-> s_we_pulse)
      else $error("write strobe width wrong");
   a_wr_stable: assert property (!flash_we_n && !$fell(flash_we_n)
      |-> $stable(flash_addr) && $stable(flash_dq_out))
      else $error("address or data moved in a write");
   a_wr_drives: assert property (!flash_we_n |-> flash_dq_oe && !flash_ce_n)
      else $error("write without data drive or chip enable");
   a_rd_no_drive: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n)
      else $error("data driven during a read");
   a_unlock_order: assert property ($fell(flash_we_n) && flash_addr == 19'h02aaa
      && flash_dq_out == 8'h55 |-> prev_a == 19'h05555 && prev_d == 8'haa)
      else $error("second unlock write without first");
   a_cmd_unlocked: assert property ($fell(flash_we_n) && flash_addr == 19'h05555
      && flash_dq_out inside {8'h90, 8'h80, 8'h10} |-> s_unlocked)
      else $error("command write not after unlock pair");
   a_reset_wait: assert property ($fell(flash_oe_n) |-> quiet >= 9'd250)
      else $error("read too soon after reset in erase");
   a_apb_answer: assert property (s_setup |=> pready ##1 !pready)
      else $error("apb answer not a one cycle pulse");
   a_unmapped_err: assert property (psel && !penable && paddr > 12'h010 |=> pready && pslverr)
      else $error("unmapped address not refused");
endmodule : flash_command_interface_monitor
bind flash_command_interface flash_command_interface_monitor u_mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
   .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
   .flash_we_n(flash_we_n));
`default_nettype wire

//--- verification/flash_command_interface_tb.sv
// Self-checking testbench of the flash command controller.
`default_nettype none
module flash_command_interface_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value.
   localparam logic [7:0] PART  = 8'h5a; // Arbitrary value.
   localparam logic [7:0] PROT  = 8'h05;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fail_mode = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic        pready, pslverr, e, dq_oe, ce_n, oe_n, we_n;
   logic [18:0] faddr;
   logic [7:0]  dq_out, dq_in;
   int          failures = 0, num_checks = 0, cyc = 0;
   logic [26:0] bad_seq [6] = '{{19'h05555, 8'haa}, {19'h02aaa, 8'h55}, {19'h05555, 8'h80},
                                {19'h05555, 8'haa}, {19'h02aaa, 8'h55}, {19'h05555, 8'h30}};
   flash_command_interface u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .flash_addr(faddr), .flash_dq_out(dq_out),
      .flash_dq_oe(dq_oe), .flash_dq_in(dq_in), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
      .flash_we_n(we_n));
   flash_device_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .PROT_MAP(PROT)) u_flash (
      .flash_addr(faddr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_ce_n(ce_n),
      .flash_oe_n(oe_n), .flash_we_n(we_n), .fail_mode(fail_mode), .flash_dq_in(dq_in));
   always #10 pclk = ~pclk;
   task automatic report_and_stop();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         report_and_stop();
      end
   end
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, x, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Starts an operation and leaves the idle status word in q.
   task automatic op(input logic [2:0] c);
      apb(1'b1, flash_host_pkg::CTRL_OFFSET, {29'h0, c});
      do apb(1'b0, flash_host_pkg::STATUS_OFFSET, 32'h0); while (q[0] !== 1'b0);
   endtask : op
   task automatic flash_rd(input logic [18:0] a);
      apb(1'b1, flash_host_pkg::ADDR_OFFSET, {13'h0, a});
      op(flash_host_pkg::OP_READ);
      apb(1'b0, flash_host_pkg::RDATA_OFFSET, 32'h0);
   endtask : flash_rd
   task automatic flash_wr(input logic [18:0] a, input logic [7:0] d);
      apb(1'b1, flash_host_pkg::ADDR_OFFSET, {13'h0, a});
      apb(1'b1, flash_host_pkg::WDATA_OFFSET, {24'h0, d});
      op(flash_host_pkg::OP_WRITE);
   endtask : flash_wr
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, flash_host_pkg::STATUS_OFFSET, 32'h0);
      chk("status", flash_host_pkg::STATUS_RESET, q);
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped", 32'h1, {31'h0, e});
      flash_rd(19'h00012);
      chk("array", 32'h12, q);
      $display("test reset and array done");
      op(flash_host_pkg::OP_SIGNATURE);
      flash_rd(19'h00000);
      chk("maker", {24'h0, MAKER}, q);
      flash_rd(19'h00001);
      chk("part", {24'h0, PART}, q);
      for (int b = 0; b < 8; b++) begin
         flash_rd({b[2:0], 16'h0002});
         chk("protect", {31'h0, PROT[b]}, q);
      end
      op(flash_host_pkg::OP_RESET);
      flash_rd(19'h00034);
      chk("array", 32'h34, q);
      $display("test signature done");
      foreach (bad_seq[i]) flash_wr(bad_seq[i][26:8], bad_seq[i][7:0]);
      flash_rd(19'h00056);
      chk("abort", 32'h56, q);
      $display("test abort done");
      op(flash_host_pkg::OP_CHIP_ERASE);
      chk("erase", 32'h2, q);
      apb(1'b1, flash_host_pkg::CTRL_OFFSET, {29'h0, flash_host_pkg::OP_SIGNATURE});
      chk("refused", 32'h1, {31'h0, e});
      apb(1'b1, flash_host_pkg::ADDR_OFFSET, 32'h0);
      do op(flash_host_pkg::OP_POLL); while (q[2] !== 1'b1);
      chk("done", 32'h4, q & 32'he);
      flash_rd(19'h00005);
      chk("erased", 32'hff, q);
      $display("test erase done");
      fail_mode <= 1'b1;
      op(flash_host_pkg::OP_CHIP_ERASE);
      do op(flash_host_pkg::OP_POLL); while (q[2] !== 1'b1);
      chk("failed", 32'hc, q & 32'he);
      op(flash_host_pkg::OP_RESET);
      chk("cleared", 32'h0, q & 32'ha);
      flash_rd(19'h00007);
      chk("after reset", 32'h07, q);
      $display("test erase failure done");
      report_and_stop();
   end
endmodule : flash_command_interface_tb
`default_nettype wire

//--- verification/flash_device_model.sv
// Behavioural parallel flash device driven by the controller's strobes.
`default_nettype none
module flash_device_model #(
   parameter logic [7:0] MAKER_CODE  = 8'h3c,
   parameter logic [7:0] PART_CODE   = 8'h5a,
   parameter logic [7:0] PROT_MAP    = 8'h05,
   parameter int         ERASE_READS = 3
) (
   input  wire logic [18:0] flash_addr,
   input  wire logic [7:0]  flash_dq_out,
   input  wire logic        flash_dq_oe,
   input  wire logic        flash_ce_n,
   input  wire logic        flash_oe_n,
   input  wire logic        flash_we_n,
   input  wire logic        fail_mode,
   output logic      [7:0]  flash_dq_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [18:0] a_q;
   logic [7:0]  rd;
   int          step = 0;
   int          left = 0;
   logic        wr_on = 0, sig = 0, busy = 0, hold = 0, tog = 0, erased = 0;
   task automatic cmd(input logic [18:0] a, input logic [7:0] d);
      if (busy || hold) begin
         if (d == 8'hf0) {busy, hold} = 2'b00;
      end else if (d == 8'hf0) begin
         sig = 0;
         step = 0;
      end else case (step)
         0, 3: step = (a == 19'h05555 && d == 8'haa) ? step + 1 : 0;
         1, 4: step = (a == 19'h02aaa && d == 8'h55) ? step + 1 : 0;
         2: begin
            sig = (a == 19'h05555 && d == 8'h90);
            step = (a == 19'h05555 && d == 8'h80) ? 3 : 0;
         end
         default: begin
            step = 0;
            busy = (a == 19'h05555 && d == 8'h10);
            left = ERASE_READS;
         end
      endcase
   endtask : cmd
   always @(negedge flash_we_n or negedge flash_ce_n)
      if (!flash_we_n && !flash_ce_n) begin
         a_q = flash_addr;
         wr_on = 1;
      end
   always @(posedge flash_we_n or posedge flash_ce_n)
      if (wr_on) begin
         wr_on = 0;
         cmd(a_q, flash_dq_out);
      end
   always @(negedge flash_oe_n or negedge flash_ce_n)
      if (!flash_oe_n && !flash_ce_n && busy) begin
         tog = ~tog;
         left = left - 1;
         if (left == 0) {busy, hold, erased} = {1'b0, fail_mode, !fail_mode};
      end
   always_comb
      if (busy) rd = {1'b0, tog, 1'(fail_mode && left == 1), 1'b0, 4'h8};
      else if (hold) rd = {1'b1, tog, 1'b1, 1'b0, 4'h8};
      else if (sig) rd = flash_addr[1] ? {7'h00, PROT_MAP[flash_addr[18:16]]}
                       : (flash_addr[0] ? PART_CODE : MAKER_CODE);
      else rd = erased ? 8'hff : flash_addr[7:0];
   assign flash_dq_in = flash_dq_oe ? flash_dq_out : ((!flash_ce_n && !flash_oe_n) ? rd : ~rd);
endmodule : flash_device_model
`default_nettype wire
